//--- bench/signal_sources.sv
// sampled signal sources feeding the trigger block
module signal_sources
    import trigger_pkg::*;
(
    // clock
    input wire logic clk_in,
    // analog levels chosen by the bench
    input wire logic [3:0][15:0] ana_in,
    // sampled outputs
    output samples_t samples_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] tick_q = 16'h0000;
    // ==========================================
    // one sample per clock; ext and digital keep moving so nothing looks stale
    always_ff @(posedge clk_in) begin
        tick_q <= tick_q + 16'h0001;
        samples_out.ch0 <= ana_in[0];
        samples_out.ch1 <= ana_in[1];
        samples_out.ch2 <= ana_in[2];
        samples_out.ch3 <= ana_in[3];
        samples_out.ext <= tick_q;
        samples_out.dig <= ~tick_q;
        // mains stand-in: square wave at a fixed period
        samples_out.line <= tick_q[5];
    end
endmodule : signal_sources

//--- bench/trigger_event_sequencer_monitor.sv
// port-level assertion checker for the trigger event sequencer
module trigger_event_sequencer_monitor
    import trigger_pkg::*;
#(
    parameter int COUNT_WIDTH = 16
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // apb
    input wire apb_req_t apb_in,
    input wire apb_rsp_t apb_out,
    // sources
    input wire samples_t samples_in,
    input wire logic [15:0] maximum_peak_value_in,
    input wire logic [15:0] minimum_peak_value_in,
    // acquisition
    input wire logic acq_start_in,
    input wire logic post_done_in,
    input wire logic trigger_out,
    input wire logic armed_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // shadow of settings and run-length counters
    logic seq_q, tmo_en_q, blk_q;
    logic [31:0] dly_q, tmo_q, idle_q, arm_q;
    wire acc = apb_in.psel && apb_in.penable && apb_out.pready;
    wire ctl = acc && apb_in.paddr == 12'h000;
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            seq_q <= 1'b0;
            tmo_en_q <= 1'b0;
            blk_q <= 1'b0;
            dly_q <= '0;
            tmo_q <= '0;
            idle_q <= '0;
            arm_q <= '0;
        end else begin
            // reads refresh the shadow, since a write may be legalised
            if (ctl) begin
                seq_q <= apb_in.pwrite ? apb_in.pwdata[0] : apb_out.prdata[0];
                tmo_en_q <= apb_in.pwrite ? apb_in.pwdata[2] : apb_out.prdata[2];
            end
            if (acc && apb_in.pwrite && apb_in.paddr == 12'h010)
                dly_q <= apb_in.pwdata;
            if (acc && apb_in.pwrite && apb_in.paddr == 12'h018)
                tmo_q <= apb_in.pwdata;
            blk_q <= trigger_out || (blk_q && !post_done_in && !ctl);
            idle_q <= armed_out ? 32'h0000_0000 : idle_q + 32'h0000_0001;
            arm_q <= armed_out ? arm_q + 32'h0000_0001 : 32'h0000_0000;
        end
    end
    // ==========================================
    // properties
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    sequence s_setup;
        apb_in.psel && !apb_in.penable;
    endsequence
    sequence s_fire;
        trigger_out;
    endsequence
    property p_pulse;
        s_fire |=> !trigger_out;
    endproperty
    property p_reset;
        disable iff (1'b0) reset_in |=> !trigger_out && !armed_out && !apb_out.pready;
    endproperty
    property p_ready;
        s_setup |=> apb_out.pready ##1 !apb_out.pready;
    endproperty
    property p_b_armed;
        seq_q && trigger_out |-> $past(armed_out);
    endproperty
    property p_rearm;
        s_fire |=> !armed_out [*2];
    endproperty
    property p_block;
        blk_q |-> !trigger_out;
    endproperty
    property p_seq_only;
        $rose(armed_out) |-> seq_q;
    endproperty
    property p_delay;
        $rose(armed_out) |-> idle_q >= dly_q;
    endproperty
    property p_tmo;
        tmo_en_q && armed_out && tmo_q != 0 |-> arm_q <= tmo_q + 32'h0000_0001;
    endproperty
    a_pulse: assert property (p_pulse) else $error("trigger longer than one cycle");
    a_reset: assert property (p_reset) else $error("outputs active after reset");
    a_ready: assert property (p_ready) else $error("pready not a single access cycle");
    a_b_armed: assert property (p_b_armed) else $error("sequence trigger while not armed");
    a_rearm: assert property (p_rearm) else $error("armed right after trigger");
    a_block: assert property (p_block) else $error("trigger during holdoff");
    a_seq_only: assert property (p_seq_only) else $error("armed in single mode");
    a_delay: assert property (p_delay) else $error("armed before delay elapsed");
    a_tmo: assert property (p_tmo) else $error("armed past reset timeout");
endmodule : trigger_event_sequencer_monitor

bind trigger_event_sequencer trigger_event_sequencer_monitor #(.COUNT_WIDTH(COUNT_WIDTH))
    u_trigger_event_sequencer_monitor (.clk_in(clk_in), .reset_in(reset_in), .apb_in(apb_in),
    .apb_out(apb_out), .samples_in(samples_in), .maximum_peak_value_in(maximum_peak_value_in),
    .minimum_peak_value_in(minimum_peak_value_in), .acq_start_in(acq_start_in),
    .post_done_in(post_done_in), .trigger_out(trigger_out), .armed_out(armed_out));

//--- bench/trigger_event_sequencer_tb.sv
// self-checking bench for the trigger event sequencer
module trigger_event_sequencer_tb import trigger_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    apb_req_t apb_in = '0;
    apb_rsp_t apb_out;
    samples_t samples;
    logic [3:0][15:0] ana = {4{16'h0800}};
    logic [15:0] max_pk = 16'h0000;
    logic [15:0] min_pk = 16'h0000;
    logic acq_start = 1'b0;
    logic post_done = 1'b0;
    logic trig, armed, e;
    logic [31:0] q;
    int n_errors = 0;
    int num_checks = 0;
    int n_trig = 0;
    int cyc = 0;
    int base;
    logic [31:0] legal_tab [7] = '{32'h0000_0101, 32'h0050_0001, 32'h0008_0040, 32'h0000_0041,
        32'h0018_0100, 32'h0010_0050, 32'h0000_2001};
    trigger_event_sequencer u_trigger_event_sequencer (.clk_in(clk_in), .reset_in(reset_in),
        .apb_in(apb_in), .apb_out(apb_out), .samples_in(samples), .maximum_peak_value_in(max_pk),
        .minimum_peak_value_in(min_pk), .acq_start_in(acq_start), .post_done_in(post_done),
        .trigger_out(trig), .armed_out(armed));
    signal_sources u_signal_sources (.clk_in(clk_in), .ana_in(ana), .samples_out(samples));
    // ==========================================
    // clock, trigger tally, watchdog
    initial forever #4 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (trig === 1'b1)
            n_trig <= n_trig + 1;
        if (cyc == 20000) begin
            n_errors = n_errors + 1;
            tally_and_finish();
        end
    end
    // ==========================================
    // tasks
    task automatic tally_and_finish();
        if (n_errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish
    task automatic check(input string what, input logic [31:0] xp, input logic [31:0] got);
        num_checks++;
        if (got !== xp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, xp, got);
        end
    endtask : check
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rq, output logic re);
        int n;
        n = 0;
        apb_in <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk_in);
        apb_in.penable <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (apb_out.pready !== 1'b1);
        check("pready wait", 32'h1, 32'(n));
        rq = apb_out.prdata;
        re = apb_out.pslverr;
        apb_in <= '0;
        @(posedge clk_in);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] wq;
        logic we;
        apb(1'b1, a, d, wq, we);
    endtask : wr
    // settle margin covers source register, detector and tally
    task automatic put(input int ch, input logic [15:0] v);
        ana[ch] <= v;
        repeat (4) @(posedge clk_in);
    endtask : put
    task automatic pls(input int ch);
        put(ch, 16'h1800);
        put(ch, 16'h0800);
    endtask : pls
    task automatic done();
        post_done <= 1'b1;
        @(posedge clk_in);
        post_done <= 1'b0;
        repeat (4) @(posedge clk_in);
    endtask : done
    task automatic rst_case(input logic [31:0] c, input logic evt);
        wr(12'h000, c);
        pls(0);
        repeat (30) @(posedge clk_in);
        pls(1);
        if (evt)
            pls(2);
        else
            repeat (80) @(posedge clk_in);
        check("restart", 32'h0, 32'(armed));
        base = n_trig;
        pls(1);
        pls(1);
        check("restart trig", 32'h0, 32'(n_trig - base));
    endtask : rst_case
    function automatic logic bad(input logic [31:0] c);
        logic [3:0] t;
        t = c[22:19];
        bad = (c[0] && (c[8:4] > 5'h03 || c[13:9] > 5'h03 || c[18:14] > 5'h03))
            || (c[0] && t inside {4'h8, 4'h9, 4'hA})
            || (c[8:4] == 5'h04 && (t != 4'h0 || c[0]))
            || (c[8:4] == 5'h05 && t != 4'h0)
            || (c[8] && !(t inside {4'h0, 4'h2, 4'h5, 4'h9, 4'hA}));
    endfunction : bad
    // ==========================================
    // scenarios
    initial begin
        repeat (10) @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
        check("armed", 32'h0, 32'(armed));
        apb(1'b0, 12'h014, '0, q, e);
        check("count", 32'h0000_0001, q);
        apb(1'b0, 12'h0FC, '0, q, e);
        check("slverr", 32'h1, 32'(e));
        for (int i = 1; i < 4; i++)
            wr(12'(4 * i), 32'h0000_1000);
        for (int s = 0; s < 3; s++) begin
            wr(12'h000, 32'(s) << 23);
            acq_start <= 1'b1;
            @(posedge clk_in);
            acq_start <= 1'b0;
            base = n_trig;
            put(0, 16'h1800);
            check("rise", 32'(s != 1), 32'(n_trig - base));
            done();
            base = n_trig;
            put(0, 16'h0800);
            check("fall", 32'(s != 0), 32'(n_trig - base));
            done();
        end
        base = n_trig;
        pls(0);
        check("holdoff", 32'h1, 32'(n_trig - base));
        done();
        foreach (legal_tab[i]) begin
            wr(12'h000, legal_tab[i]);
            apb(1'b0, 12'h000, '0, q, e);
            check("legal", 32'h0, 32'(bad(q)));
        end
        wr(12'h010, 32'h0000_0014);
        wr(12'h014, 32'h0000_0003);
        wr(12'h018, 32'h0000_003C);
        wr(12'h000, 32'h0000_8201);
        apb(1'b0, 12'h000, '0, q, e);
        check("ctrl", 32'h0000_8201, q);
        base = n_trig;
        pls(1);
        pls(0);
        pls(1);
        repeat (30) @(posedge clk_in);
        check("armed", 32'h1, 32'(armed));
        pls(1);
        pls(1);
        apb(1'b0, 12'h01C, '0, q, e);
        check("status", 32'h0000_000B, q);
        check("early", 32'h0, 32'(n_trig - base));
        pls(1);
        check("final", 32'h1, 32'(n_trig - base));
        check("rearm", 32'h0, 32'(armed));
        done();
        pls(1);
        pls(1);
        pls(1);
        check("no a", 32'h1, 32'(n_trig - base));
        rst_case(32'h0000_8203, 1'b1);
        rst_case(32'h0000_8205, 1'b0);
        rst_case(32'h0000_8207, 1'b1);
        rst_case(32'h0000_8207, 1'b0);
        max_pk <= 16'h5000;
        min_pk <= 16'h1000;
        wr(12'h020, 32'h0000_0001);
        for (int i = 1; i < 4; i++) begin
            apb(1'b0, 12'(4 * i), '0, q, e);
            check("find", 32'h0000_2000, q);
        end
        wr(12'h000, 32'h0000_0040);
        wr(12'h004, 32'h0000_1000);
        wr(12'h020, 32'h0000_0001);
        apb(1'b0, 12'h004, '0, q, e);
        check("find ext", 32'h0000_1000, q);
        wr(12'h000, 32'h0000_8201);
        pls(0);
        repeat (30) @(posedge clk_in);
        reset_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
        check("armed", 32'h0, 32'(armed));
        apb(1'b0, 12'h01C, '0, q, e);
        check("status", 32'h0, q);
        tally_and_finish();
    end
endmodule : trigger_event_sequencer_tb

//--- core/trigger_defines.svh
// constants for the trigger event sequencer
`ifndef TRIGGER_DEFINES_SVH
`define TRIGGER_DEFINES_SVH
// ==========================================
// register offsets (byte addresses)
`define REG_CTRL_OFFSET 12'h000
`define REG_LEVEL_A_OFFSET 12'h004
`define REG_LEVEL_B_OFFSET 12'h008
`define REG_LEVEL_R_OFFSET 12'h00C
`define REG_DELAY_OFFSET 12'h010
`define REG_COUNT_OFFSET 12'h014
`define REG_TIMEOUT_OFFSET 12'h018
`define REG_STATUS_OFFSET 12'h01C
`define REG_FIND_OFFSET 12'h020
`define REG_PEAK_OFFSET 12'h024
`define REG_HOLDOFF_OFFSET 12'h028
// ==========================================
// control field positions
`define CTRL_SEQ_BIT 0
`define CTRL_RST_EVT_BIT 1
`define CTRL_RST_TMO_BIT 2
`define CTRL_SRC_A_LSB 4
`define CTRL_SRC_B_LSB 9
`define CTRL_SRC_R_LSB 14
`define CTRL_TYPE_A_LSB 19
`define CTRL_SLOPE_A_LSB 23
`define CTRL_SLOPE_B_LSB 25
`define CTRL_SLOPE_R_LSB 27
// ==========================================
// reset values
`define CTRL_RESET 32'h0000_0000
`define LEVEL_RESET 16'h0000
`define DELAY_RESET 32'h0000_0000
`define COUNT_RESET 16'h0001
`define TIMEOUT_RESET 32'h0000_0000
`define HOLDOFF_RESET 32'h0000_0000
`endif

//--- core/trigger_event_sequencer.sv
// trigger event sequencer: edge detection, A->B sequence with R as reset event, apb registers
// ==========================================
`include "trigger_defines.svh"
module trigger_event_sequencer
    import trigger_pkg::*;
#(
    parameter int COUNT_WIDTH = 16
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,

    // apb slave
    input wire apb_req_t apb_in,
    output apb_rsp_t apb_out,

    // sampled sources
    input wire samples_t samples_in,
    input wire logic [15:0] maximum_peak_value_in,
    input wire logic [15:0] minimum_peak_value_in,

    // acquisition control
    input wire logic acq_start_in,
    input wire logic post_done_in,
    output logic trigger_out,
    output logic armed_out
);
    // ==========================================
    // elaboration check
    if (COUNT_WIDTH < 1 || COUNT_WIDTH > 16) begin : g_bad_width
        $error("COUNT_WIDTH must be 1..16");
    end

    typedef struct packed {
        apb_rsp_t rsp;
        logic [31:0] ctrl;
        logic [15:0] level_a;
        logic [15:0] level_b;
        logic [15:0] level_r;
        logic [31:0] delay;
        logic [COUNT_WIDTH-1:0] count;
        logic [31:0] timeout;
        logic [31:0] holdoff;

        seq_state_t state;
        logic [31:0] timer;
        logic [31:0] tmo_timer;
        logic [COUNT_WIDTH-1:0] b_count;
        logic post_seen;
        logic trig;

        logic [15:0] prev_a;
        logic [15:0] prev_b;
        logic [15:0] prev_r;
        logic prev_valid;
        logic [31:0] trig_total;
        logic armed;
    } state_t;

    state_t s_q;
    state_t s_d;

    // ==========================================
    // source selection and crossing detection
    function automatic logic [15:0] pick(input source_t src, input samples_t smp);
        logic [15:0] v;
        v = 16'h0000;
        case (src)
            SRC_CH0: v = smp.ch0;
            SRC_CH1: v = smp.ch1;
            SRC_CH2: v = smp.ch2;
            SRC_CH3: v = smp.ch3;
            SRC_EXT: v = smp.ext;
            SRC_LINE: v = {smp.line, 15'h0000};
            default: begin
                if (src[4]) begin
                    v = {smp.dig[src[3:0]], 15'h0000};
                end
            end
        endcase

        return v;
    endfunction : pick

    // samples arrive regardless of display state, so no display gating
    function automatic logic crossed(input logic [15:0] prev, input logic [15:0] cur,
                                     input logic [15:0] lvl, input logic [1:0] slope);
        logic rise;
        logic fall;
        rise = (prev < lvl) && (cur >= lvl);
        fall = (prev >= lvl) && (cur < lvl);

        case (slope)
            SLOPE_POS: return rise;
            SLOPE_NEG: return fall;
            SLOPE_EITHER: return rise | fall;
            default: return 1'b0;
        endcase
    endfunction : crossed

    function automatic logic is_analog(input logic [4:0] src);
        return src < 5'h04;
    endfunction : is_analog

    // ==========================================
    // compatibility forcing of control writes
    function automatic logic [31:0] legalise(input logic [31:0] c);
        logic [31:0] r;
        logic [3:0] t;
        logic [4:0] sa;
        r = c;
        sa = c[`CTRL_SRC_A_LSB +: 5];
        t = c[`CTRL_TYPE_A_LSB +: 4];

        if (c[`CTRL_SEQ_BIT]) begin
            // only analog channels serve sequence stages
            if (!is_analog(sa)) r[`CTRL_SRC_A_LSB +: 5] = SRC_CH0;
            if (!is_analog(c[`CTRL_SRC_B_LSB +: 5])) r[`CTRL_SRC_B_LSB +: 5] = SRC_CH0;
            if (!is_analog(c[`CTRL_SRC_R_LSB +: 5])) r[`CTRL_SRC_R_LSB +: 5] = SRC_CH0;
            if (t >= TYPE_SETUP_HOLD) r[`CTRL_TYPE_A_LSB +: 4] = TYPE_EDGE;
        end else begin
            if (sa == SRC_EXT || sa == SRC_LINE) begin
                r[`CTRL_TYPE_A_LSB +: 4] = TYPE_EDGE;
            end else if (sa[4]) begin
                if (!(t == TYPE_EDGE || t == TYPE_WIDTH || t == TYPE_TIMEOUT ||
                      t == TYPE_STATE || t == TYPE_PATTERN)) begin
                    r[`CTRL_TYPE_A_LSB +: 4] = TYPE_EDGE;
                end
            end else if (!sa[4] && sa > 5'h05) begin
                r[`CTRL_SRC_A_LSB +: 5] = SRC_CH0;
            end
        end

        for (int i = 0; i < 3; i++) begin
            if (r[`CTRL_SLOPE_A_LSB + 2*i +: 2] == 2'b11) r[`CTRL_SLOPE_A_LSB + 2*i +: 2] = SLOPE_EITHER;
        end

        r[3] = 1'b0;
        r[31:29] = 3'b000;
        return r;
    endfunction : legalise

    logic [15:0] cur_a;
    logic [15:0] cur_b;
    logic [15:0] cur_r;
    logic hit_a;
    logic hit_b;
    logic hit_r;

    logic [15:0] found_level;
    logic src_a_auto;
    logic wr;
    logic rd;

    always_comb begin
        cur_a = pick(source_t'(s_q.ctrl[`CTRL_SRC_A_LSB +: 5]), samples_in);
        cur_b = pick(source_t'(s_q.ctrl[`CTRL_SRC_B_LSB +: 5]), samples_in);
        cur_r = pick(source_t'(s_q.ctrl[`CTRL_SRC_R_LSB +: 5]), samples_in);

        // first sample after start has no history, so no crossing then
        hit_a = s_q.prev_valid && crossed(s_q.prev_a, cur_a, s_q.level_a, s_q.ctrl[`CTRL_SLOPE_A_LSB +: 2]);
        hit_b = s_q.prev_valid && crossed(s_q.prev_b, cur_b, s_q.level_b, s_q.ctrl[`CTRL_SLOPE_B_LSB +: 2]);
        hit_r = s_q.prev_valid && crossed(s_q.prev_r, cur_r, s_q.level_r, s_q.ctrl[`CTRL_SLOPE_R_LSB +: 2]);

        // half of the peak difference, as specified
        found_level = 16'((maximum_peak_value_in - minimum_peak_value_in) >> 1);
        src_a_auto = is_analog(s_q.ctrl[`CTRL_SRC_A_LSB +: 5]) || s_q.ctrl[`CTRL_SRC_A_LSB + 4];

        wr = apb_in.psel && apb_in.penable && apb_in.pwrite;
        rd = apb_in.psel && !apb_in.penable && !apb_in.pwrite;
    end

    // ==========================================
    // next state
    always_comb begin
        s_d = s_q;
        s_d.trig = 1'b0;
        s_d.rsp.pready = apb_in.psel && !apb_in.penable; // one wait-free access cycle
        s_d.rsp.pslverr = 1'b0;

        // ---- apb reads, data set up during setup phase
        if (rd) begin
            case (apb_in.paddr)
                `REG_CTRL_OFFSET: s_d.rsp.prdata = s_q.ctrl;
                `REG_LEVEL_A_OFFSET: s_d.rsp.prdata = {16'h0000, s_q.level_a};
                `REG_LEVEL_B_OFFSET: s_d.rsp.prdata = {16'h0000, s_q.level_b};
                `REG_LEVEL_R_OFFSET: s_d.rsp.prdata = {16'h0000, s_q.level_r};
                `REG_DELAY_OFFSET: s_d.rsp.prdata = s_q.delay;
                `REG_COUNT_OFFSET: s_d.rsp.prdata = 32'(s_q.count);
                `REG_TIMEOUT_OFFSET: s_d.rsp.prdata = s_q.timeout;
                `REG_STATUS_OFFSET: s_d.rsp.prdata = {14'h0000, 16'(s_q.b_count), s_q.state};
                `REG_PEAK_OFFSET: s_d.rsp.prdata = {maximum_peak_value_in, minimum_peak_value_in};
                `REG_HOLDOFF_OFFSET: s_d.rsp.prdata = s_q.holdoff;
                `REG_FIND_OFFSET: s_d.rsp.prdata = s_q.trig_total;
                default: begin
                    s_d.rsp.prdata = 32'h0000_0000;
                    s_d.rsp.pslverr = 1'b1;
                end
            endcase
        end else if (apb_in.psel && !apb_in.penable) begin
            s_d.rsp.prdata = 32'h0000_0000;
            case (apb_in.paddr)
                `REG_CTRL_OFFSET, `REG_LEVEL_A_OFFSET, `REG_LEVEL_B_OFFSET, `REG_LEVEL_R_OFFSET,
                `REG_DELAY_OFFSET, `REG_COUNT_OFFSET, `REG_TIMEOUT_OFFSET, `REG_FIND_OFFSET,
                `REG_HOLDOFF_OFFSET: s_d.rsp.pslverr = 1'b0;
                default: s_d.rsp.pslverr = 1'b1;
            endcase
        end

        // ---- sequencer
        s_d.prev_a = cur_a;
        s_d.prev_b = cur_b;
        s_d.prev_r = cur_r;
        s_d.prev_valid = 1'b1;
        if (acq_start_in) begin
            s_d.prev_valid = 1'b0;
        end

        case (s_q.state)
            ST_WAIT_A: begin
                if (hit_a) begin
                    s_d.b_count = '0;
                    s_d.tmo_timer = 32'h0000_0000;
                    if (!s_q.ctrl[`CTRL_SEQ_BIT]) begin
                        s_d.trig = 1'b1;
                        s_d.state = ST_HOLDOFF;
                        s_d.timer = 32'h0000_0000;
                        s_d.post_seen = 1'b0;
                    end else if (s_q.delay == 32'h0000_0000) begin
                        s_d.state = ST_WAIT_B;
                    end else begin
                        s_d.state = ST_DELAY;
                        s_d.timer = 32'h0000_0001;
                    end
                end
            end

            ST_DELAY: begin
                // b crossings here are not looked at
                s_d.timer = s_q.timer + 32'h0000_0001;
                s_d.tmo_timer = s_q.tmo_timer + 32'h0000_0001;
                if (s_q.timer >= s_q.delay) begin
                    s_d.state = ST_WAIT_B;
                end
                if ((s_q.ctrl[`CTRL_RST_EVT_BIT] && hit_r) ||
                    (s_q.ctrl[`CTRL_RST_TMO_BIT] && s_q.tmo_timer + 32'h0000_0001 >= s_q.timeout)) begin
                    s_d.state = ST_WAIT_A;
                    s_d.timer = 32'h0000_0000;
                    s_d.tmo_timer = 32'h0000_0000;
                end
            end

            ST_WAIT_B: begin
                s_d.tmo_timer = s_q.tmo_timer + 32'h0000_0001;
                if (hit_b && s_q.b_count + 1'b1 >= s_q.count) begin
                    s_d.trig = 1'b1;
                    s_d.state = ST_HOLDOFF;
                    s_d.timer = 32'h0000_0000;
                    s_d.post_seen = 1'b0;
                    s_d.b_count = '0;
                end else if ((s_q.ctrl[`CTRL_RST_EVT_BIT] && hit_r) ||
                             (s_q.ctrl[`CTRL_RST_TMO_BIT] &&
                              s_q.tmo_timer + 32'h0000_0001 >= s_q.timeout)) begin
                    s_d.state = ST_WAIT_A;
                    s_d.b_count = '0;
                    s_d.tmo_timer = 32'h0000_0000;
                end else if (hit_b) begin
                    s_d.b_count = s_q.b_count + 1'b1;
                end
            end

            ST_HOLDOFF: begin
                // holdoff time counts only after the post-trigger part is filled
                if (post_done_in) begin
                    s_d.post_seen = 1'b1;
                end
                if (s_q.post_seen) begin
                    s_d.timer = s_q.timer + 32'h0000_0001;
                    if (s_q.timer >= s_q.holdoff) begin
                        s_d.state = ST_WAIT_A;
                        s_d.timer = 32'h0000_0000;
                        s_d.prev_valid = 1'b0;
                    end
                end
            end

            default: s_d.state = ST_WAIT_A;
        endcase

        if (s_q.trig) begin
            s_d.trig_total = s_q.trig_total + 32'h0000_0001;
        end

        // ---- apb writes, applied on the access edge
        if (wr) begin
            case (apb_in.paddr)
                `REG_CTRL_OFFSET: begin
                    s_d.ctrl = legalise(apb_in.pwdata);
                    s_d.state = ST_WAIT_A;
                    s_d.b_count = '0;
                end
                `REG_LEVEL_A_OFFSET: s_d.level_a = apb_in.pwdata[15:0];
                `REG_LEVEL_B_OFFSET: s_d.level_b = apb_in.pwdata[15:0];
                `REG_LEVEL_R_OFFSET: s_d.level_r = apb_in.pwdata[15:0];
                `REG_DELAY_OFFSET: s_d.delay = apb_in.pwdata;
                `REG_COUNT_OFFSET: begin
                    s_d.count = apb_in.pwdata[COUNT_WIDTH-1:0];
                    if (apb_in.pwdata[COUNT_WIDTH-1:0] == '0) s_d.count = COUNT_WIDTH'(1);
                end
                `REG_TIMEOUT_OFFSET: s_d.timeout = apb_in.pwdata;
                `REG_HOLDOFF_OFFSET: s_d.holdoff = apb_in.pwdata;

                `REG_FIND_OFFSET: begin
                    // refused for external and line sources
                    if (apb_in.pwdata[0] && src_a_auto) begin
                        s_d.level_a = found_level;
                        if (s_q.ctrl[`CTRL_SEQ_BIT]) begin
                            s_d.level_b = found_level;
                            if (s_q.ctrl[`CTRL_RST_EVT_BIT]) s_d.level_r = found_level;
                        end
                    end
                end
                default: s_d.rsp.pslverr = s_q.rsp.pslverr;
            endcase
        end
        s_d.armed = (s_d.state == ST_WAIT_B);
    end

    // ==========================================
    // registers
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            s_q <= '0;
            s_q.ctrl <= `CTRL_RESET;
            s_q.level_a <= `LEVEL_RESET;
            s_q.level_b <= `LEVEL_RESET;
            s_q.level_r <= `LEVEL_RESET;
            s_q.delay <= `DELAY_RESET;
            s_q.count <= COUNT_WIDTH'(`COUNT_RESET);
            s_q.timeout <= `TIMEOUT_RESET;
            s_q.holdoff <= `HOLDOFF_RESET;
            s_q.state <= ST_WAIT_A;
        end else begin
            s_q <= s_d;
        end
    end

    assign apb_out = s_q.rsp;
    assign trigger_out = s_q.trig;
    assign armed_out = s_q.armed;
endmodule : trigger_event_sequencer

//--- core/trigger_pkg.sv
// types for the trigger event sequencer
package trigger_pkg;
    // ==========================================
    // sources: 0..3 analog, 4 external, 5 line, 16..31 digital
    typedef enum logic [4:0] {
        SRC_CH0 = 5'h00,
        SRC_CH1 = 5'h01,
        SRC_CH2 = 5'h02,
        SRC_CH3 = 5'h03,
        SRC_EXT = 5'h04,
        SRC_LINE = 5'h05,
        SRC_DIG0 = 5'h10
    } source_t;
    typedef enum logic [3:0] {
        TYPE_EDGE = 4'h0,
        TYPE_GLITCH = 4'h1,
        TYPE_WIDTH = 4'h2,
        TYPE_RUNT = 4'h3,
        TYPE_WINDOW = 4'h4,
        TYPE_TIMEOUT = 4'h5,
        TYPE_INTERVAL = 4'h6,
        TYPE_SLEW = 4'h7,
        TYPE_SETUP_HOLD = 4'h8,
        TYPE_STATE = 4'h9,
        TYPE_PATTERN = 4'hA
    } trig_type_t;
    typedef enum logic [1:0] {
        SLOPE_POS = 2'b00,
        SLOPE_NEG = 2'b01,
        SLOPE_EITHER = 2'b10
    } slope_t;
    // gray path: wait_a -> delay -> wait_b -> holdoff
    typedef enum logic [1:0] {
        ST_WAIT_A = 2'b00,
        ST_DELAY = 2'b01,
        ST_WAIT_B = 2'b11,
        ST_HOLDOFF = 2'b10
    } seq_state_t;
    typedef struct packed {
        logic [15:0] ch0;
        logic [15:0] ch1;
        logic [15:0] ch2;
        logic [15:0] ch3;
        logic [15:0] ext;
        logic line;
        logic [15:0] dig;
    } samples_t;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;
endpackage : trigger_pkg
